// ===== include/twc_params.svh
`ifndef TWC_PARAMS_SVH
`define TWC_PARAMS_SVH

// memory map landmarks
`define TWC_ADDR_FUNC_CMD 8'hFE
`define TWC_ADDR_TOP 8'hFF
`define TWC_ADDR_WRITE_LIMIT 8'h4F
`define TWC_FILL_BYTE 8'hFF
// eeprom block address ranges
`define TWC_BLK0_LO 8'h60
`define TWC_BLK0_HI 8'h7F
`define TWC_BLK1_LO 8'h80
`define TWC_BLK1_HI 8'h9F
// function command codes
`define TWC_CMD_COPY0 8'h42
`define TWC_CMD_COPY1 8'h44
`define TWC_CMD_RECALL0 8'hB2
`define TWC_CMD_RECALL1 8'hB4
`define TWC_CMD_LOCK0 8'h63
`define TWC_CMD_LOCK1 8'h66
`define TWC_CMD_READ_ID 8'h39
// programming time
`define TWC_CLK_PERIOD_NS 5
`define TWC_NV_PROGRAM_TIME_MS 2
`define TWC_NV_PROGRAM_CYCLES ((`TWC_NV_PROGRAM_TIME_MS * 1000000) / `TWC_CLK_PERIOD_NS)
`define TWC_ID_BYTES 8
// reset values
`define TWC_LOCK_RESET 2'h0

`endif

// ===== include/twc_pkg.sv
package twc_pkg;
  typedef enum logic [2:0] {
    TWC_IDLE = 3'b001,
    TWC_MEM = 3'b010,
    TWC_ID = 3'b100
  } twc_rd_state_t;
  typedef enum logic [1:0] {
    TWC_NV_IDLE = 2'b01,
    TWC_NV_BUSY = 2'b10
  } twc_nv_state_t;
endpackage

// ===== hdl/twc_prog_timer.sv
`timescale 1ns/10ps
`include "twc_params.svh"

module twc_prog_timer #(
  parameter int unsigned PROG_CYCLES = `TWC_NV_PROGRAM_CYCLES
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // control
  input wire logic start,
  output logic busy,
  output logic done
);
  import twc_pkg::*;

  twc_nv_state_t state_reg;
  logic [31:0] count_reg;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= TWC_NV_IDLE;
      count_reg <= 32'h00000000;
    end else begin
      unique case (state_reg)
        TWC_NV_IDLE: begin
          if (start) begin
            state_reg <= TWC_NV_BUSY;
            count_reg <= PROG_CYCLES - 32'h00000001;
          end
        end
        TWC_NV_BUSY: begin
          if (count_reg == 32'h00000000) begin
            state_reg <= TWC_NV_IDLE;
          end else begin
            count_reg <= count_reg - 32'h00000001;
          end
        end
      endcase
    end
  end

  assign busy = (state_reg == TWC_NV_BUSY);
  assign done = (state_reg == TWC_NV_BUSY) && (count_reg == 32'h00000000);
endmodule // twc_prog_timer

// ===== hdl/twc_cmd_layer.sv
`timescale 1ns/10ps
`include "twc_params.svh"

// Overview of operation
// [R1] read bytes go out msb first, starting at the written memory address
// [R2] address advances after each byte's last bit so next byte follows ack
// [R3] reads past FFh return FFh for every further byte
// [R4] reserved addresses return whatever memory gives; contents unchecked
// [R5] master ends a read with nack then stop or repeated start
// [R6] function command is a one-byte write at FEh; code selects operation
// [R7] bytes after the command code in the same write are discarded
// [R8] reads of FEh return undefined data
// [R9] 42h copies shadow to block 0, 44h to block 1
// [R10] copy to a locked block is ignored entirely
// [R11] busy status bit is 1 while a copy runs
// [R12] during copy, writes starting inside target block are ignored
// [R13] during copy, reads and other writes proceed normally
// [R14] programming starts after code acknowledge and lasts about 2ms
// [R15] master waits for programming end before next copy or lock
// [R16] B2h recalls block 0 to shadow, B4h recalls block 1
// [R17] 63h locks block 0, 66h locks block 1
// [R18] lock acts only when lock-arming bit is 1
// [R19] a locked block stays locked and is never programmed again
// [R20] after 39h an addressless eight-byte read returns the 64-bit id
// [R21] auto-incremented write bytes past 4Fh or landing on FEh are dropped; code drops past-4Fh bytes only when the write started at or below 4Fh
// [R22] direction bit 0 means write, 1 means read
// [R23] busy bit clears when programming finishes

module twc_cmd_layer #(
  parameter int unsigned PROG_CYCLES = `TWC_NV_PROGRAM_CYCLES,
  parameter logic [63:0] ROM_ID = 64'h0123_4567_89AB_CDEF // value is arbitrary
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // bit layer: transaction framing
  input wire logic frame_start,
  input wire logic frame_stop,
  input wire logic dir_bit,
  // bit layer: received bytes (pulse per acknowledged byte)
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  // bit layer: transmit shift
  input wire logic tx_bit_req,
  input wire logic tx_byte_done,
  input wire logic master_ack,
  output logic tx_bit,
  // memory access port
  output logic mem_rd_en,
  output logic [7:0] mem_rd_addr,
  input wire logic [7:0] mem_rd_data,
  output logic mem_wr_en,
  output logic [7:0] mem_wr_addr,
  output logic [7:0] mem_wr_data,
  // nonvolatile control
  input wire logic lock_arm,
  output logic nv_copy_start,
  output logic nv_recall_start,
  output logic nv_block_sel,
  output logic [1:0] block_locked,
  output logic eeprom_busy_flag
);
  import twc_pkg::*;

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------
  function automatic logic in_block(input logic [7:0] a, input logic blk);
    if (blk)
      in_block = (a >= `TWC_BLK1_LO) && (a <= `TWC_BLK1_HI);
    else
      in_block = (a >= `TWC_BLK0_LO) && (a <= `TWC_BLK0_HI);
  endfunction

  // ----------------------------------------------------------------
  // write-side byte tracking
  // ----------------------------------------------------------------
  logic [3:0] byte_idx_reg;
  logic [7:0] mem_addr_byte;
  logic [7:0] wr_ptr_reg;
  logic start_addr_blocked_reg;
  logic func_cmd_frame_reg;
  logic id_armed_reg;
  logic past_top_reg;
  logic prog_busy;
  logic prog_done;
  logic prog_start;
  logic tgt_blk_reg;
  logic [7:0] func_cmd_code;
  logic is_cmd;

  assign func_cmd_code = rx_byte;
  // command byte is the first data byte of a write framed at FEh
  assign is_cmd = rx_valid && !dir_bit && (byte_idx_reg == 4'h2) && func_cmd_frame_reg; // R6

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      byte_idx_reg <= 4'h0;
      mem_addr_byte <= 8'h00;
      func_cmd_frame_reg <= 1'b0;
      start_addr_blocked_reg <= 1'b0;
    end else if (frame_start) begin
      byte_idx_reg <= 4'h0;
    end else if (rx_valid && !dir_bit && byte_idx_reg != 4'hF) begin
      byte_idx_reg <= byte_idx_reg + 4'h1;
      if (byte_idx_reg == 4'h1) begin
        mem_addr_byte <= rx_byte;
        func_cmd_frame_reg <= (rx_byte == `TWC_ADDR_FUNC_CMD); // R6
        // start address decides; later bytes of the same write follow it
        start_addr_blocked_reg <= prog_busy && in_block(rx_byte, tgt_blk_reg); // R12 R13
      end
    end else if (rx_valid && byte_idx_reg == 4'h0) begin
      byte_idx_reg <= 4'h1; // slave address byte
    end
  end

  // ----------------------------------------------------------------
  // memory writes
  // ----------------------------------------------------------------
  logic wr_ok;
  assign wr_ok = rx_valid && !dir_bit && (byte_idx_reg >= 4'h2) && !func_cmd_frame_reg // R7
    && !start_addr_blocked_reg
    // only a write that ran on from 4Fh or below is cut; shadow blocks above stay writable
    && !((wr_ptr_reg > `TWC_ADDR_WRITE_LIMIT) && (mem_addr_byte <= `TWC_ADDR_WRITE_LIMIT)) // R21
    && (wr_ptr_reg != `TWC_ADDR_FUNC_CMD); // R21

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ptr_reg <= 8'h00;
    end else if (rx_valid && !dir_bit && byte_idx_reg == 4'h1) begin
      wr_ptr_reg <= rx_byte;
    end else if (rx_valid && !dir_bit && byte_idx_reg >= 4'h2 && wr_ptr_reg != 8'hFF) begin
      wr_ptr_reg <= wr_ptr_reg + 8'h01;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mem_wr_en <= 1'b0;
      mem_wr_addr <= 8'h00;
      mem_wr_data <= 8'h00;
    end else begin
      mem_wr_en <= wr_ok;
      if (wr_ok) begin
        mem_wr_addr <= wr_ptr_reg;
        mem_wr_data <= rx_byte;
      end
    end
  end

  // ----------------------------------------------------------------
  // function commands
  // ----------------------------------------------------------------
  logic is_copy;
  logic is_lock;
  logic cmd_blk;
  logic locked_tgt;
  assign is_copy = (func_cmd_code == `TWC_CMD_COPY0) || (func_cmd_code == `TWC_CMD_COPY1);
  assign is_lock = (func_cmd_code == `TWC_CMD_LOCK0) || (func_cmd_code == `TWC_CMD_LOCK1);
  assign cmd_blk = (func_cmd_code == `TWC_CMD_COPY1) || (func_cmd_code == `TWC_CMD_LOCK1)
    || (func_cmd_code == `TWC_CMD_RECALL1);
  assign locked_tgt = block_locked[cmd_blk];
  // copy and lock start at command acknowledge; locked target or unarmed lock do nothing
  assign prog_start = is_cmd && !prog_busy && !locked_tgt // R10 R19 R15
    && (is_copy || (is_lock && lock_arm)); // R9 R17 R18 R14

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      nv_copy_start <= 1'b0;
      nv_recall_start <= 1'b0;
      nv_block_sel <= 1'b0;
      tgt_blk_reg <= 1'b0;
    end else begin
      nv_copy_start <= prog_start && is_copy; // R9
      nv_recall_start <= is_cmd && ((func_cmd_code == `TWC_CMD_RECALL0)
        || (func_cmd_code == `TWC_CMD_RECALL1)); // R16
      if (is_cmd) begin
        nv_block_sel <= cmd_blk;
      end
      if (prog_start) begin
        tgt_blk_reg <= cmd_blk;
      end
    end
  end

  // lock commits at the end of its programming cycle; never cleared
  logic lock_pend_reg;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      block_locked <= `TWC_LOCK_RESET;
      lock_pend_reg <= 1'b0;
    end else begin
      if (prog_start) begin
        lock_pend_reg <= is_lock;
      end
      if (prog_done && lock_pend_reg) begin
        block_locked[tgt_blk_reg] <= 1'b1; // R17 R19
      end
    end
  end

  twc_prog_timer #(
    .PROG_CYCLES(PROG_CYCLES)
  ) u_timer (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .start(prog_start),
    .busy(prog_busy),
    .done(prog_done)
  );

  assign eeprom_busy_flag = prog_busy; // R11 R23

  // ----------------------------------------------------------------
  // read engine
  // ----------------------------------------------------------------
  twc_rd_state_t rd_state_reg;
  logic [7:0] rd_ptr_reg;
  logic [7:0] shift_reg;
  logic [2:0] id_idx_reg;
  logic load_pend_reg;
  logic rd_start;
  logic [7:0] id_byte;

  assign rd_start = rx_valid && byte_idx_reg == 4'h0 && dir_bit; // R22
  // byte after the current one; wraps to the first if the master keeps acking
  assign id_byte = ROM_ID[63 - {id_idx_reg + 3'h1, 3'b000} -: 8];
  assign mem_rd_en = load_pend_reg;
  assign mem_rd_addr = rd_ptr_reg;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      id_armed_reg <= 1'b0;
    end else if (is_cmd && func_cmd_code == `TWC_CMD_READ_ID) begin
      id_armed_reg <= 1'b1; // R20
    end else if (rd_start || (rx_valid && !dir_bit && byte_idx_reg == 4'h1)) begin
      id_armed_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_state_reg <= TWC_IDLE;
      rd_ptr_reg <= 8'h00;
      id_idx_reg <= 3'h0;
      past_top_reg <= 1'b0;
      load_pend_reg <= 1'b0;
    end else begin
      load_pend_reg <= 1'b0;
      unique case (rd_state_reg)
        TWC_IDLE: begin
          if (rd_start) begin
            rd_state_reg <= id_armed_reg ? TWC_ID : TWC_MEM; // R20
            rd_ptr_reg <= mem_addr_byte; // R1 R4 R8
            past_top_reg <= 1'b0;
            id_idx_reg <= 3'h0;
            load_pend_reg <= !id_armed_reg;
          end
        end
        TWC_MEM: begin
          if (frame_stop || frame_start || (tx_byte_done && !master_ack)) begin
            rd_state_reg <= TWC_IDLE; // R5
          end else if (tx_byte_done) begin
            // advance on tx_byte_done with the ack; next msb reaches shift_reg two cycles later
            if (rd_ptr_reg == `TWC_ADDR_TOP) begin
              past_top_reg <= 1'b1; // R3
            end
            rd_ptr_reg <= rd_ptr_reg + 8'h01; // R2
            load_pend_reg <= 1'b1;
          end
        end
        TWC_ID: begin
          if (frame_stop || frame_start || (tx_byte_done && !master_ack)) begin
            rd_state_reg <= TWC_IDLE;
          end else if (tx_byte_done) begin
            id_idx_reg <= id_idx_reg + 3'h1; // R20
          end
        end
        default: rd_state_reg <= TWC_IDLE;
      endcase
    end
  end

  // memory data appear one cycle after the read enable
  logic load_dly_reg;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      load_dly_reg <= 1'b0;
      shift_reg <= 8'h00;
    end else begin
      load_dly_reg <= load_pend_reg;
      if (rd_start && id_armed_reg) begin
        shift_reg <= ROM_ID[63 -: 8];
      end else if (rd_state_reg == TWC_ID && tx_byte_done) begin
        shift_reg <= id_byte; // R20
      end else if (load_dly_reg) begin
        shift_reg <= past_top_reg ? `TWC_FILL_BYTE : mem_rd_data; // R3
      end else if (tx_bit_req) begin
        shift_reg <= {shift_reg[6:0], 1'b1}; // R1
      end
    end
  end

  assign tx_bit = shift_reg[7]; // R1
endmodule // twc_cmd_layer

// ===== testbench/twc_cmd_layer_properties.sv
`timescale 1ns/10ps
`include "twc_params.svh"

module twc_cmd_layer_properties #(
  parameter int unsigned PROG_CYCLES = 10
) (
  // watched ports
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  input wire logic mem_wr_en,
  input wire logic [7:0] mem_wr_addr,
  input wire logic [7:0] mem_wr_data,
  input wire logic nv_copy_start,
  input wire logic nv_recall_start,
  input wire logic nv_block_sel,
  input wire logic [1:0] block_locked,
  input wire logic eeprom_busy_flag
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // busy length is counted, a repetition of that size would not unroll
  int unsigned busy_cnt;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy_cnt <= 0;
    end else begin
      busy_cnt <= eeprom_busy_flag ? busy_cnt + 1 : 0;
    end
  end
  copy_busy_a: assert property (nv_copy_start |-> eeprom_busy_flag)
    else $error("copy started without busy");
  copy_code_a: assert property (nv_copy_start |-> $past(rx_valid)
    && $past(rx_byte) inside {`TWC_CMD_COPY0, `TWC_CMD_COPY1}
    && nv_block_sel == ($past(rx_byte) == `TWC_CMD_COPY1))
    else $error("copy without copy code");
  recall_code_a: assert property (nv_recall_start |-> $past(rx_valid)
    && $past(rx_byte) inside {`TWC_CMD_RECALL0, `TWC_CMD_RECALL1}
    && nv_block_sel == ($past(rx_byte) == `TWC_CMD_RECALL1))
    else $error("recall without recall code");
  locked_copy_a: assert property (nv_copy_start |-> !block_locked[nv_block_sel])
    else $error("copy into locked block");
  busy_copy_a: assert property (nv_copy_start |-> !$past(eeprom_busy_flag))
    else $error("copy while busy");
  lock_keep_a: assert property (1'b1 |=> ($past(block_locked) & ~block_locked) == 2'h0)
    else $error("lock released");
  busy_len_a: assert property ($fell(eeprom_busy_flag) |-> busy_cnt == PROG_CYCLES)
    else $error("busy length wrong");
  lock_time_a: assert property ($changed(block_locked) |->
    $past(eeprom_busy_flag) || $past(eeprom_busy_flag, 2))
    else $error("lock outside programming");
  wr_limit_a: assert property ($past(mem_wr_en, 2)
    && $past(mem_wr_addr, 2) == `TWC_ADDR_WRITE_LIMIT |-> !mem_wr_en)
    else $error("write beyond limit");
  wr_data_a: assert property (mem_wr_en |-> $past(rx_valid) && mem_wr_data == $past(rx_byte))
    else $error("write data not received byte");
endmodule // twc_cmd_layer_properties

bind twc_cmd_layer twc_cmd_layer_properties #(.PROG_CYCLES(PROG_CYCLES)) chk (.core_clk,
  .sys_rst, .rx_valid, .rx_byte, .mem_wr_en, .mem_wr_addr, .mem_wr_data, .nv_copy_start,
  .nv_recall_start, .nv_block_sel, .block_locked, .eeprom_busy_flag);

// ===== testbench/twc_host_model.sv
`timescale 1ns/10ps

module twc_host_model (
  // clock
  input wire logic core_clk,
  // bit layer toward the device
  output logic frame_start,
  output logic frame_stop,
  output logic dir_bit,
  output logic rx_valid,
  output logic [7:0] rx_byte,
  output logic tx_bit_req,
  output logic tx_byte_done,
  output logic master_ack,
  input wire logic tx_bit
);
  // pulse lines, msb first: frame_start, frame_stop, rx_valid, tx_bit_req, tx_byte_done
  logic [4:0] pulse_reg;
  assign {frame_start, frame_stop, rx_valid, tx_bit_req, tx_byte_done} = pulse_reg;
  initial begin
    pulse_reg = 5'h00;
    {dir_bit, master_ack} = 2'h0;
    rx_byte = 8'h00;
  end
  task automatic start(input logic rd);
    @(posedge core_clk);
    pulse_reg <= 5'h10;
    dir_bit <= rd;
    @(posedge core_clk);
    pulse_reg <= 5'h00;
  endtask
  task automatic stop();
    @(posedge core_clk);
    pulse_reg <= 5'h08;
    @(posedge core_clk);
    pulse_reg <= 5'h00;
  endtask
  task automatic put(input logic [7:0] b);
    @(posedge core_clk);
    pulse_reg <= 5'h04;
    rx_byte <= b;
    @(posedge core_clk);
    pulse_reg <= 5'h00;
    // released data never repeats the last byte
    rx_byte <= ~b;
  endtask
  // nack on the last byte ends the read at a byte boundary
  task automatic get(input logic ack, output logic [7:0] b);
    b = 8'h00;
    repeat (3) @(posedge core_clk);
    for (int i = 0; i < 8; i++) begin
      #1 b = {b[6:0], tx_bit};
      @(posedge core_clk);
      pulse_reg <= 5'h02;
      @(posedge core_clk);
      pulse_reg <= 5'h00;
    end
    @(posedge core_clk);
    pulse_reg <= 5'h01;
    master_ack <= ack;
    @(posedge core_clk);
    pulse_reg <= 5'h00;
    master_ack <= 1'b0;
  endtask
endmodule // twc_host_model

// ===== testbench/twc_cmd_layer_tb_top.sv
`timescale 1ns/10ps
`include "twc_params.svh"

module twc_cmd_layer_tb_top;
  import twc_pkg::*;
  // long enough that a write frame right after a copy still meets the busy window
  localparam int unsigned PROG = 30;
  localparam logic [63:0] ID = 64'h5A3C_96E1_0F78_B24D; // value is arbitrary
  localparam logic [7:0] SLV = 8'hB2;
  logic core_clk, sys_rst, lock_arm, tx_bit, mem_rd_en, mem_wr_en, nv_copy_start;
  logic nv_recall_start, nv_block_sel, eeprom_busy_flag, frame_start, frame_stop, dir_bit;
  logic rx_valid, tx_bit_req, tx_byte_done, master_ack;
  logic [7:0] rx_byte, mem_rd_addr, mem_rd_data, mem_wr_addr, mem_wr_data, last_wr;
  logic [1:0] block_locked;
  logic rd_q = 1'b0;
  int mismatches, comparisons, n_wr, n_copy, n_recall;

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // pattern memory; data outside the read window is inverted
  assign mem_rd_data = (mem_rd_en || rd_q) ? mem_rd_addr ^ 8'hA5 : ~mem_rd_addr;
  always @(posedge core_clk) begin
    rd_q <= mem_rd_en;
    n_copy += nv_copy_start;
    n_recall += nv_recall_start;
    n_wr += mem_wr_en;
    if (mem_wr_en) last_wr <= mem_wr_addr;
  end

  twc_host_model host (.core_clk, .frame_start, .frame_stop, .dir_bit, .rx_valid, .rx_byte,
    .tx_bit_req, .tx_byte_done, .master_ack, .tx_bit);
  twc_cmd_layer #(.PROG_CYCLES(PROG), .ROM_ID(ID)) uut (.core_clk, .sys_rst, .frame_start,
    .frame_stop, .dir_bit, .rx_valid, .rx_byte, .tx_bit_req, .tx_byte_done, .master_ack,
    .tx_bit, .mem_rd_en, .mem_rd_addr, .mem_rd_data, .mem_wr_en, .mem_wr_addr, .mem_wr_data,
    .lock_arm, .nv_copy_start, .nv_recall_start, .nv_block_sel, .block_locked,
    .eeprom_busy_flag);

  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 40 && eeprom_busy_flag !== 1'b0; i++) @(posedge core_clk);
    #1 check("busy", eeprom_busy_flag, 1'b0);
  endtask
  task automatic cmd(input logic [7:0] code);
    host.start(1'b0);
    host.put(SLV);
    host.put(`TWC_ADDR_FUNC_CMD);
    host.put(code);
    host.put(8'h55);
    host.stop();
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.start(1'b0);
    host.put(SLV);
    host.put(a);
    host.put(d);
    host.stop();
  endtask
  task automatic s_busy();
    int w;
    cmd(`TWC_CMD_COPY0);
    w = n_wr;
    wr(8'h60, 8'h12);
    #1 check("blocked", n_wr - w, 0);
    wr(8'h80, 8'h34);
    #1 check("outside", n_wr - w, 1);
    check("outside addr", last_wr, 8'h80);
    check("busy", eeprom_busy_flag, 1'b1);
    wait_idle();
    w = n_wr;
    wr(8'h60, 8'h56);
    #1 check("after copy", n_wr - w, 1);
    check("after addr", last_wr, 8'h60);
  endtask
  task automatic s_read();
    logic [7:0] b;
    host.start(1'b0);
    host.put(SLV);
    host.put(8'hFC);
    host.start(1'b1);
    host.put(SLV | 8'h01);
    for (int i = 0; i < 6; i++) begin
      host.get(i < 5, b);
      // the command address reads undefined, so it is skipped
      if (i != 2) check("rd", b, i < 4 ? 8'(8'hFC + i) ^ 8'hA5 : 8'hFF);
    end
    host.stop();
  endtask
  task automatic s_write();
    int w;
    w = n_wr;
    host.start(1'b0);
    host.put(SLV);
    host.put(8'h4E);
    host.put(8'h11);
    host.put(8'h22);
    host.put(8'h33);
    host.stop();
    #1 check("writes", n_wr - w, 2);
    check("last", last_wr, 8'h4F);
  endtask
  task automatic s_commands();
    logic [7:0] codes [4] = '{`TWC_CMD_COPY0, `TWC_CMD_COPY1, `TWC_CMD_RECALL0,
      `TWC_CMD_RECALL1};
    int w, c, r;
    w = n_wr;
    for (int i = 0; i < 4; i++) begin
      c = n_copy;
      r = n_recall;
      cmd(codes[i]);
      #1 check("copy", n_copy - c, i < 2);
      check("recall", n_recall - r, i >= 2);
      check("block", nv_block_sel, i % 2);
      if (i < 2) check("busy", eeprom_busy_flag, 1'b1);
      wait_idle();
    end
    check("writes", n_wr - w, 0);
  endtask
  task automatic s_id();
    logic [7:0] b;
    cmd(`TWC_CMD_READ_ID);
    host.start(1'b1);
    host.put(SLV | 8'h01);
    for (int i = 0; i < 8; i++) begin
      host.get(i < 7, b);
      check("id", b, ID[63-8*i -: 8]);
    end
    host.stop();
  endtask
  task automatic s_lock();
    int c;
    cmd(`TWC_CMD_LOCK0);
    wait_idle();
    check("locks", block_locked, 2'h0);
    @(posedge core_clk);
    lock_arm <= 1'b1;
    cmd(`TWC_CMD_LOCK0);
    wait_idle();
    check("locks", block_locked, 2'h1);
    c = n_copy;
    cmd(`TWC_CMD_COPY0);
    wait_idle();
    check("copy", n_copy - c, 0);
    cmd(`TWC_CMD_LOCK1);
    wait_idle();
    check("locks", block_locked, 2'h3);
  endtask
  task automatic wrap_up();
    if (mismatches == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    sys_rst = 1'b1;
    lock_arm = 1'b0;
    repeat (6) @(posedge core_clk);
    sys_rst <= 1'b0;
    s_read();
    s_write();
    s_commands();
    s_busy();
    s_id();
    s_lock();
    wrap_up();
  end
  // the tests need some 600 cycles
  initial begin
    #100000;
    mismatches++;
    wrap_up();
  end
endmodule // twc_cmd_layer_tb_top
